// File: rtl/cpd_channel_protect_diag.sv
// protection, latch-off, limp-home retry and output monitor for eight channels
// assumes synchronous comparator inputs and a single-cycle register port
// Function
// - start on high threshold, switch to low after delay; a short off keeps the phase reached
// - off longer than two sync periods restores high threshold
// - overcurrent beyond shutdown delay latches channel off and sets fault flag
// - per-channel overtemperature latches off and sets same fault flag
// - writing 1 to unlatch bit releases latch; bit self-clears
// - in limp-home, channels 2 and 3 follow the input pins
// - limp-home retries at 10, 20, 40 ms, eight each, then 80 ms
// - input low over two sync periods restarts retry sequence
// - retry periods scale by doubling from the first stage
// - channel diagnostics independent unless paired in parallel
// - monitor bits show drain voltage below threshold, refreshed on read
// - one probe current enable per channel
// - open-load indication never changes switching state
// - open-load summary is OR of monitor bits of off, probed channels
// - sync period typically 5 us, qualifies off and input-low times
//
// The plain strobed port and the placing of the registers were decided locally.
`include "cpd_params.svh"
`default_nettype none
module cpd_channel_protect_diag #(
  parameter int THR_CYC = `CPD_THRSW_CYC,
  parameter int RETRY_CYC = `CPD_RETRY_CYC
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [7:0] addr,
  input wire logic [31:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [31:0] rdata,
  input wire logic [7:0] ovlHigh,
  input wire logic [7:0] ovlLow,
  input wire logic [7:0] overTemp,
  input wire logic [7:0] vdsBelow,
  input wire logic limpMode,
  input wire logic [1:0] inPin,
  output logic [7:0] chanOn,
  output logic [7:0] highThrSel,
  output logic [7:0] probeEn,
  output logic openLoadSummary,
  output logic irq
);
  localparam int N = `CPD_NCH;

  typedef struct packed {
    logic [7:0] ctrl;
    logic [7:0] unlatch;
    logic [7:0] probe;
    logic [7:0] mask;
    logic [3:0] par;
    logic [7:0] fault;
    logic [7:0] mon;
    logic [7:0] on;
    logic [7:0] hiThr;
    logic olSum;
    logic irq;
    logic [31:0] rdata;
    cpd_pkg::cpd_chan_type [7:0] st;
    logic [7:0][14:0] onCnt;
    logic [7:0][9:0] ovlCnt;
    logic [7:0][9:0] offCnt;
    logic [1:0][23:0] retryCnt;
    logic [1:0][4:0] retryNum;
    logic [1:0][9:0] lowCnt;
  } cpd_state_type;

  cpd_state_type q;
  cpd_state_type d;
  logic [1:0] rstPipe;
  logic rstSync;

  // reset released through two flops so the state flops never see an asynchronous release
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rstPipe <= 2'h0;
    end else begin
      rstPipe <= {rstPipe[0], 1'b1};
    end
  end
  assign rstSync = rstPipe[1];

  // period doubles per stage of eight retries, capped at the last stage
  function automatic logic [23:0] retryLimit(input logic [4:0] num);
    logic [1:0] stage;
    stage = (num >= 5'(`CPD_RETRY_LAST)) ? 2'h3 : num[4:3];
    retryLimit = 24'(RETRY_CYC) << stage;
  endfunction

  function automatic logic hit(input logic [7:0] a, input logic [7:0] target);
    hit = (a == target);
  endfunction

  logic [7:0] dem;
  logic [7:0] trip;
  logic [7:0] tripAll;

  always_comb begin
    d = q;
    dem = 8'h00;
    trip = 8'h00;
    tripAll = 8'h00;
    d.rdata = 32'h0;
    // limp-home hands channels 2 and 3 to the pins, all others off
    if (limpMode) begin
      dem[2] = inPin[0];
      dem[3] = inPin[1];
    end else begin
      dem = q.ctrl;
    end
    // detection per channel; monitor bits never enter here
    for (int i = 0; i < N; i++) begin
      if (q.st[i] == cpd_pkg::CH_HIGH || q.st[i] == cpd_pkg::CH_LOW) begin
        if ((q.st[i] == cpd_pkg::CH_HIGH) ? ovlHigh[i] : ovlLow[i]) begin
          d.ovlCnt[i] = q.ovlCnt[i] + 10'h1;
          if (q.ovlCnt[i] == 10'(`CPD_SHUT_CYC - 1)) begin
            trip[i] = 1'b1;
          end
        end else begin
          d.ovlCnt[i] = 10'h0;
        end
        if (overTemp[i]) begin
          trip[i] = 1'b1;
        end
      end else begin
        d.ovlCnt[i] = 10'h0;
      end
    end
    // a trip spreads only to the partner of a paralleled pair
    for (int p = 0; p < N / 2; p++) begin
      tripAll[2*p] = trip[2*p] | (q.par[p] & trip[2*p+1]);
      tripAll[2*p+1] = trip[2*p+1] | (q.par[p] & trip[2*p]);
    end
    for (int i = 0; i < N; i++) begin
      case (q.st[i])
        cpd_pkg::CH_OFF, cpd_pkg::CH_LATCH: begin
          // long off-time forgets the elapsed on-time
          if (q.offCnt[i] < 10'(`CPD_OFFQ_CYC)) begin
            d.offCnt[i] = q.offCnt[i] + 10'h1;
          end else begin
            d.onCnt[i] = 15'h0;
          end
          if (q.st[i] == cpd_pkg::CH_LATCH) begin
            if (q.unlatch[i]) begin
              d.st[i] = cpd_pkg::CH_OFF;
            end
          end else if (dem[i]) begin
            d.offCnt[i] = 10'h0;
            // resume the phase the on-time counter says
            d.st[i] = (d.onCnt[i] >= 15'(THR_CYC)) ? cpd_pkg::CH_LOW : cpd_pkg::CH_HIGH;
          end
        end
        cpd_pkg::CH_HIGH, cpd_pkg::CH_LOW: begin
          if (q.onCnt[i] < 15'(THR_CYC)) begin
            d.onCnt[i] = q.onCnt[i] + 15'h1;
          end
          // high threshold until the switch delay has run
          if (q.onCnt[i] >= 15'(THR_CYC - 1)) begin
            d.st[i] = cpd_pkg::CH_LOW;
          end
          if (!dem[i]) begin
            d.st[i] = cpd_pkg::CH_OFF;
          end
        end
        default: begin
          d.st[i] = cpd_pkg::CH_OFF;
        end
      endcase
      // latch wins over everything else this cycle
      if (tripAll[i]) begin
        d.st[i] = cpd_pkg::CH_LATCH;
        d.offCnt[i] = 10'h0;
      end
    end
    // limp-home retry timers for the two pin-driven channels
    for (int k = 0; k < 2; k++) begin
      if (inPin[k]) begin
        d.lowCnt[k] = 10'h0;
      end else if (q.lowCnt[k] < 10'(`CPD_OFFQ_CYC)) begin
        d.lowCnt[k] = q.lowCnt[k] + 10'h1;
      end
      if (q.lowCnt[k] >= 10'(`CPD_OFFQ_CYC)) begin
        d.retryNum[k] = 5'h0;
        d.retryCnt[k] = 24'h0;
      end else if (limpMode && inPin[k] && q.st[k+2] == cpd_pkg::CH_LATCH && !tripAll[k+2]) begin
        if (q.retryCnt[k] >= retryLimit(q.retryNum[k]) - 24'h1) begin
          d.retryCnt[k] = 24'h0;
          d.st[k+2] = cpd_pkg::CH_OFF;
          if (q.retryNum[k] < 5'(`CPD_RETRY_LAST)) begin
            d.retryNum[k] = q.retryNum[k] + 5'h1;
          end
        end else begin
          d.retryCnt[k] = q.retryCnt[k] + 24'h1;
        end
      end else begin
        d.retryCnt[k] = 24'h0;
      end
    end
    // self-clear one cycle after the write, whether or not a latch was released
    d.unlatch = 8'h00;
    // refresh monitor bits on each read of the monitor register
    if (rd && hit(addr, `CPD_ADDR_MON)) begin
      d.mon = vdsBelow;
    end
    d.fault = q.fault;
    if (rd) begin
      case (addr)
        `CPD_ADDR_CTRL: d.rdata = {24'h0, q.ctrl};
        `CPD_ADDR_UNLATCH: d.rdata = {24'h0, q.unlatch};
        `CPD_ADDR_PROBE: d.rdata = {24'h0, q.probe};
        `CPD_ADDR_MON: d.rdata = {24'h0, vdsBelow};
        `CPD_ADDR_FAULT: begin
          d.rdata = {24'h0, q.fault};
          d.fault = 8'h00;
        end
        `CPD_ADDR_MASK: d.rdata = {24'h0, q.mask};
        `CPD_ADDR_PAR: d.rdata = {28'h0, q.par};
        `CPD_ADDR_STAT: d.rdata = {30'h0, limpMode, q.olSum};
        default: d.rdata = 32'h0;
      endcase
    end
    // new faults set after the read-clear, so a set wins
    d.fault = d.fault | tripAll;
    if (wr) begin
      case (addr)
        `CPD_ADDR_CTRL: d.ctrl = wdata[7:0];
        `CPD_ADDR_UNLATCH: d.unlatch = wdata[7:0];
        // one probe enable bit per channel
        `CPD_ADDR_PROBE: d.probe = wdata[7:0];
        `CPD_ADDR_MASK: d.mask = wdata[7:0];
        `CPD_ADDR_PAR: d.par = wdata[3:0];
        default: d.ctrl = q.ctrl;
      endcase
    end
    for (int i = 0; i < N; i++) begin
      d.on[i] = (d.st[i] == cpd_pkg::CH_HIGH) || (d.st[i] == cpd_pkg::CH_LOW);
      d.hiThr[i] = (d.st[i] != cpd_pkg::CH_LOW);
    end
    // summary over channels that are off with probe current on
    d.olSum = |(q.mon & q.probe & ~q.on);
    d.irq = |(d.fault & q.mask);
  end

  always_ff @(posedge clk or negedge rstSync) begin
    if (!rstSync) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign rdata = q.rdata;
  assign chanOn = q.on;
  assign highThrSel = q.hiThr;
  assign probeEn = q.probe;
  assign openLoadSummary = q.olSum;
  assign irq = q.irq;

  sequence seqUnlatchWr;
    wr && addr == `CPD_ADDR_UNLATCH && wdata[7:0] != 8'h00;
  endsequence
  sequence seqLatchedThenFree;
    q.st[1] == cpd_pkg::CH_LATCH ##1 q.st[1] != cpd_pkg::CH_LATCH;
  endsequence

  AST_UNLATCH_SELF_CLEAR: assert property (@(posedge clk) disable iff (!rstSync)
    seqUnlatchWr |=> q.unlatch == $past(wdata[7:0]) ##1 (q.unlatch == 8'h00 || $past(wr && addr == `CPD_ADDR_UNLATCH)))
    else $error("unlatch bit did not clear itself");
  AST_LATCH_NEEDS_UNLATCH: assert property (@(posedge clk) disable iff (!rstSync)
    seqLatchedThenFree |-> $past(q.unlatch[1], 1))
    else $error("channel 1 left latch without unlatch");
  AST_HIGH_PHASE_BOUND: assert property (@(posedge clk) disable iff (!rstSync)
    q.st[0] == cpd_pkg::CH_HIGH |-> q.onCnt[0] < 15'(THR_CYC))
    else $error("high threshold held past switch delay");
  AST_LONG_OFF_RESTORES: assert property (@(posedge clk) disable iff (!rstSync)
    (q.st[0] == cpd_pkg::CH_OFF && q.offCnt[0] == 10'(`CPD_OFFQ_CYC)) |=> q.onCnt[0] == 15'h0)
    else $error("long off-time did not restore high threshold");
  AST_OVERLOAD_TRIP: assert property (@(posedge clk) disable iff (!rstSync)
    (q.on[1] && q.ovlCnt[1] == 10'(`CPD_SHUT_CYC - 1) && (q.hiThr[1] ? ovlHigh[1] : ovlLow[1]))
    |=> q.st[1] == cpd_pkg::CH_LATCH && q.fault[1] && !q.on[1])
    else $error("overload did not latch channel 1");
  AST_OVERTEMP_TRIP: assert property (@(posedge clk) disable iff (!rstSync)
    (q.on[4] && overTemp[4]) |=> q.st[4] == cpd_pkg::CH_LATCH && q.fault[4])
    else $error("overtemperature did not latch channel 4");
  AST_LIMP_PIN_CHANNEL: assert property (@(posedge clk) disable iff (!rstSync)
    (limpMode && !inPin[0] && q.on[2]) |=> !q.on[2])
    else $error("limp channel 2 stayed on with pin low");
  AST_MONITOR_REFRESH: assert property (@(posedge clk) disable iff (!rstSync)
    (rd && addr == `CPD_ADDR_MON) |=> q.mon == $past(vdsBelow) && rdata[7:0] == $past(vdsBelow))
    else $error("monitor bits not refreshed by read");
  AST_OPEN_LOAD_SUMMARY: assert property (@(posedge clk) disable iff (!rstSync)
    1'b1 |=> openLoadSummary == $past(|(q.mon & q.probe & ~q.on)))
    else $error("open-load summary mismatch");
  AST_RETRY_RESET: assert property (@(posedge clk) disable iff (!rstSync)
    q.lowCnt[0] == 10'(`CPD_OFFQ_CYC) |=> q.retryNum[0] == 5'h0)
    else $error("retry sequence not reset after long low input");
  AST_IRQ_LEVEL: assert property (@(posedge clk) disable iff (!rstSync)
    irq == |(q.fault & $past(q.mask)))
    else $error("interrupt does not follow masked faults");

  // channel 1 and pin channel 2 are the ones that trip and retry in normal use of the tests
  sequence seqPairTrip;
    q.par[0] && q.on[1] ##1 q.st[1] == cpd_pkg::CH_LATCH;
  endsequence
  sequence seqRetryExpire;
    limpMode && inPin[0] && q.st[2] == cpd_pkg::CH_LATCH && !tripAll[2] && q.lowCnt[0] < 10'(`CPD_OFFQ_CYC)
      && q.retryCnt[0] == retryLimit(q.retryNum[0]) - 24'h1;
  endsequence

  // a trip and a read-clear in one cycle must leave the flag set
  AST_THR_SWITCH: assert property (@(posedge clk) disable iff (!rstSync)
    (q.st[0] == cpd_pkg::CH_HIGH && q.onCnt[0] == 15'(THR_CYC - 1) && dem[0] && !tripAll[0]) |=> !highThrSel[0])
    else $error("threshold did not switch after delay");
  AST_FAULT_SET_WINS: assert property (@(posedge clk) disable iff (!rstSync)
    (|tripAll) |=> (q.fault & $past(tripAll)) == $past(tripAll))
    else $error("new fault lost against read clear");
  AST_PAIR_TRIP: assert property (@(posedge clk) disable iff (!rstSync)
    seqPairTrip |-> q.st[0] == cpd_pkg::CH_LATCH)
    else $error("paired channel 0 did not follow channel 1");
  AST_LIMP_OTHERS_OFF: assert property (@(posedge clk) disable iff (!rstSync)
    limpMode |=> (q.on & 8'hF3) == 8'h00)
    else $error("non-pin channel on in limp-home");
  AST_RETRY_EXPIRE: assert property (@(posedge clk) disable iff (!rstSync)
    seqRetryExpire |=> q.st[2] == cpd_pkg::CH_OFF && q.retryCnt[0] == 24'h0)
    else $error("retry period end did not release channel 2");
  AST_RETRY_COUNT: assert property (@(posedge clk) disable iff (!rstSync)
    seqRetryExpire |=> q.retryNum[0] == $past(q.retryNum[0]) + 5'h1 || q.retryNum[0] == 5'(`CPD_RETRY_LAST))
    else $error("retry number did not advance");
  AST_MON_HOLDS: assert property (@(posedge clk) disable iff (!rstSync)
    !(rd && addr == `CPD_ADDR_MON) |=> $stable(q.mon))
    else $error("monitor bits changed without a read");
  AST_PROBE_WRITE: assert property (@(posedge clk) disable iff (!rstSync)
    (wr && addr == `CPD_ADDR_PROBE) |=> probeEn == $past(wdata[7:0]))
    else $error("probe enables do not follow write");
  AST_OPEN_LOAD_KEEPS_ON: assert property (@(posedge clk) disable iff (!rstSync)
    (q.on[0] && dem[0] && !tripAll[0]) |=> chanOn[0])
    else $error("channel 0 dropped without trip or demand");
endmodule
`default_nettype wire

// File: rtl/cpd_params.svh
// constants for the channel protection and diagnosis block
// assumes a 100 MHz core clock; all times are counted on it
`ifndef CPD_PARAMS_SVH
`define CPD_PARAMS_SVH
`define CPD_NCH 8
`define CPD_CLK_MHZ 100
// times in microseconds or milliseconds, cycles derived from them
`define CPD_SYNC_US 5
`define CPD_SYNC_CYC (`CPD_SYNC_US * `CPD_CLK_MHZ)
`define CPD_OFFQ_CYC (2 * `CPD_SYNC_CYC)
`define CPD_SHUT_US 7
`define CPD_SHUT_CYC (`CPD_SHUT_US * `CPD_CLK_MHZ)
`define CPD_THRSW_US 170
`define CPD_THRSW_CYC (`CPD_THRSW_US * `CPD_CLK_MHZ)
`define CPD_RETRY_MS 10
`define CPD_RETRY_CYC (`CPD_RETRY_MS * 1000 * `CPD_CLK_MHZ)
`define CPD_RETRY_PER_STAGE 8
`define CPD_RETRY_LAST 24
// register byte addresses
`define CPD_ADDR_CTRL 8'h00
`define CPD_ADDR_UNLATCH 8'h04
`define CPD_ADDR_PROBE 8'h08
`define CPD_ADDR_MON 8'h0C
`define CPD_ADDR_FAULT 8'h10
`define CPD_ADDR_MASK 8'h14
`define CPD_ADDR_PAR 8'h18
`define CPD_ADDR_STAT 8'h1C
// status register fields
`define CPD_STAT_OLSUM 0
`define CPD_STAT_LIMP 1
`endif

// File: rtl/cpd_pkg.sv
// types for the channel protection and diagnosis block
// assumes cpd_params.svh is included by the user of these types
`default_nettype none
package cpd_pkg;
  typedef enum logic [1:0] {
    CH_OFF = 2'b00,
    CH_HIGH = 2'b01,
    CH_LOW = 2'b10,
    CH_LATCH = 2'b11
  } cpd_chan_type;
endpackage
`default_nettype wire

// File: testbench/channel_protect_diag_tb_top.sv
// self-checking bench for the channel protection and diagnosis block
// assumes the register map of cpd_params.svh and a 100 MHz clock
`include "cpd_params.svh"
`default_nettype none
module channel_protect_diag_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int THR = 50;
  localparam int RTY = 200;
  logic clk, rst_n, wr, rd, limpMode, openLoadSummary, irq;
  logic [7:0] addr, ovlHigh, ovlLow, overTemp, vdsBelow, chanOn, highThrSel, probeEn;
  logic [7:0] shortCh, hotCh, openCh, c, p;
  logic [31:0] wdata, rdata, d;
  logic [1:0] inPin;
  int n_errors, n_compared, t;
  cpd_channel_protect_diag #(.THR_CYC(THR), .RETRY_CYC(RTY)) cpd_channel_protect_diag_i (.clk(clk),
    .rst_n(rst_n), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .ovlHigh(ovlHigh),
    .ovlLow(ovlLow), .overTemp(overTemp), .vdsBelow(vdsBelow), .limpMode(limpMode), .inPin(inPin),
    .chanOn(chanOn), .highThrSel(highThrSel), .probeEn(probeEn), .openLoadSummary(openLoadSummary), .irq(irq));
  cpd_load_model cpd_load_model_i (.chanOn(chanOn), .probeEn(probeEn), .shortCh(shortCh), .hotCh(hotCh),
    .openCh(openCh), .ovlHigh(ovlHigh), .ovlLow(ovlLow), .overTemp(overTemp), .vdsBelow(vdsBelow));
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  task automatic cmp(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_compared++;
    if (got !== exp) begin
      n_errors++;
      $display("CHECK FAILED %s expected %0h seen %0h", what, exp, got);
    end
  endtask
  task automatic wreg(input logic [7:0] a, input logic [31:0] v);
    @(posedge clk);
    wr <= 1'b1;
    addr <= a;
    wdata <= v;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task automatic rreg(input logic [7:0] a, output logic [31:0] v);
    @(posedge clk);
    rd <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd <= 1'b0;
    #1 v = rdata;
  endtask
  // bounded wait for one channel to reach a level, n counts the cycles
  task automatic waiton(input int ch, input logic v, input int lim, output int n);
    n = 0;
    while (chanOn[ch] !== v && n < lim) begin
      @(posedge clk);
      #1 n++;
    end
    if (chanOn[ch] !== v) begin
      n_errors++;
      $display("CHECK FAILED chanOn[%0d] expected %0h seen %0h", ch, v, chanOn[ch]);
    end
  endtask
  task automatic waitcyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  function automatic logic [7:0] vexp(input logic [7:0] on, input logic [7:0] pr, input logic [7:0] op);
    return on | (pr & op);
  endfunction
  function automatic logic olexp(input logic [7:0] on, input logic [7:0] pr, input logic [7:0] op);
    return |(~on & pr & op);
  endfunction
  // retry stages double every eight retries
  function automatic logic rok(input int n, input int k);
    int e;
    e = RTY << (k / 8);
    return (n >= e - 5) && (n <= e + 5);
  endfunction
  task automatic give_verdict;
    $display("compared %0d mismatches %0d", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  initial begin
    repeat (100000) @(posedge clk);
    n_errors++;
    give_verdict();
  end
  initial begin
    {rst_n, wr, rd, limpMode, addr, wdata, inPin, shortCh, hotCh, openCh} = '0;
    n_errors = 0;
    n_compared = 0;
    void'($urandom(64));
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge clk);
    for (int a = 0; a <= 8'h20; a += 4) begin
      rreg(8'(a), d);
      cmp("reset read", 32'h0, d);
    end
    $display("test reset done");
    for (int i = 0; i < 6; i++) begin
      c = 8'($urandom);
      p = 8'($urandom);
      openCh <= 8'($urandom);
      wreg(`CPD_ADDR_CTRL, 32'(c));
      wreg(`CPD_ADDR_PROBE, 32'(p));
      waitcyc(5);
      rreg(`CPD_ADDR_MON, d);
      cmp("monitor", 32'(vexp(c, p, openCh)), d);
      waitcyc(3);
      cmp("probeEn", 32'(p), 32'(probeEn));
      cmp("summary", 32'(olexp(c, p, openCh)), 32'(openLoadSummary));
      cmp("chanOn", 32'(c), 32'(chanOn));
    end
    wreg(`CPD_ADDR_CTRL, 32'h0);
    wreg(`CPD_ADDR_PROBE, 32'h0);
    waitcyc(`CPD_OFFQ_CYC + 20);
    $display("test monitor done");
    wreg(`CPD_ADDR_CTRL, 32'h1);
    waiton(0, 1'b1, 10, t);
    cmp("thr at on", 32'h1, 32'(highThrSel[0]));
    waitcyc(THR + 5);
    cmp("thr after delay", 32'h0, 32'(highThrSel[0]));
    wreg(`CPD_ADDR_CTRL, 32'h0);
    waitcyc(100);
    wreg(`CPD_ADDR_CTRL, 32'h1);
    waitcyc(5);
    cmp("thr short off", 32'h0, 32'(highThrSel[0]));
    wreg(`CPD_ADDR_CTRL, 32'h0);
    waitcyc(`CPD_OFFQ_CYC + 20);
    wreg(`CPD_ADDR_CTRL, 32'h1);
    waitcyc(THR - 10);
    cmp("thr restored", 32'h1, 32'(highThrSel[0]));
    $display("test threshold done");
    wreg(`CPD_ADDR_MASK, 32'h2);
    wreg(`CPD_ADDR_CTRL, 32'h3);
    waiton(1, 1'b1, 10, t);
    shortCh <= 8'h02;
    waiton(1, 1'b0, 800, t);
    cmp("shutdown delay", 32'h1, 32'(t > 690 && t < 710));
    waitcyc(3);
    cmp("irq set", 32'h1, 32'(irq));
    cmp("other channel", 32'h1, 32'(chanOn[0]));
    rreg(`CPD_ADDR_FAULT, d);
    cmp("fault flag", 32'h2, d);
    waitcyc(2);
    cmp("irq cleared", 32'h0, 32'(irq));
    waitcyc(50);
    cmp("stays latched", 32'h0, 32'(chanOn[1]));
    shortCh <= 8'h00;
    wreg(`CPD_ADDR_UNLATCH, 32'h2);
    waiton(1, 1'b1, 10, t);
    cmp("unlatched", 32'h1, 32'(chanOn[1]));
    rreg(`CPD_ADDR_UNLATCH, d);
    cmp("unlatch bit", 32'h0, d);
    hotCh <= 8'h10;
    wreg(`CPD_ADDR_CTRL, 32'h13);
    waitcyc(10);
    cmp("hot channel", 32'h3, 32'(chanOn));
    cmp("masked irq", 32'h0, 32'(irq));
    rreg(`CPD_ADDR_FAULT, d);
    cmp("hot fault", 32'h10, d);
    hotCh <= 8'h00;
    wreg(`CPD_ADDR_UNLATCH, 32'h10);
    wreg(`CPD_ADDR_PAR, 32'h1);
    shortCh <= 8'h02;
    waiton(1, 1'b0, 800, t);
    waitcyc(2);
    cmp("paired off", 32'h0, 32'(chanOn[1:0]));
    rreg(`CPD_ADDR_FAULT, d);
    cmp("paired fault", 32'h3, d);
    shortCh <= 8'h00;
    wreg(`CPD_ADDR_PAR, 32'h0);
    wreg(`CPD_ADDR_UNLATCH, 32'h3);
    wreg(`CPD_ADDR_CTRL, 32'h0);
    $display("test latch done");
    limpMode <= 1'b1;
    inPin <= 2'b01;
    waitcyc(1);
    waiton(2, 1'b1, 10, t);
    cmp("limp on", 32'h1, 32'(chanOn[2]));
    rreg(`CPD_ADDR_STAT, d);
    cmp("status", 32'h2, d);
    shortCh <= 8'h04;
    for (int k = 0; k < 17; k++) begin
      waiton(2, 1'b0, 800, t);
      waiton(2, 1'b1, 1000, t);
      cmp("retry period", 32'h1, 32'(rok(t, k)));
    end
    inPin <= 2'b00;
    waitcyc(`CPD_OFFQ_CYC + 20);
    inPin <= 2'b01;
    waiton(2, 1'b1, 1000, t);
    waiton(2, 1'b0, 800, t);
    waiton(2, 1'b1, 1000, t);
    cmp("retry restart", 32'h1, 32'(rok(t, 0)));
    $display("test limp done");
    give_verdict();
  end
endmodule
`default_nettype wire

// File: testbench/cpd_load_model.sv
// load and comparator model standing behind the eight low-side channels
// assumes chanOn and probeEn from the block, fault selectors from the bench
`default_nettype none
module cpd_load_model (
  input wire logic [7:0] chanOn,
  input wire logic [7:0] probeEn,
  input wire logic [7:0] shortCh,
  input wire logic [7:0] hotCh,
  input wire logic [7:0] openCh,
  output logic [7:0] ovlHigh,
  output logic [7:0] ovlLow,
  output logic [7:0] overTemp,
  output logic [7:0] vdsBelow
);
  timeunit 1ns;
  timeprecision 1ps;
  // comparator levels
  // a shorted load only draws current while the switch conducts
  assign ovlHigh = chanOn & shortCh;
  assign ovlLow = chanOn & shortCh;
  assign overTemp = hotCh;
  // drain pulled low
  // a load that is not connected lets the probe current pull the drain low
  assign vdsBelow = chanOn | (probeEn & openCh);
endmodule
`default_nettype wire
